// ---- inc/ufm_defines.vh ----
// How it works
// - Flush mask bit 0 empties the receive ring at once.
// - Flush mask bit 1 empties the transmit ring and buffer; both bits may be set.
// - A flush takes one clock; queued transmit bytes are dropped, never sent.
// - With flow control on, a full receive ring deasserts request-to-send.
// - Clear-to-send read gives 0 when not asserted and 1 when asserted.
// - Without a clear-to-send pin the read always gives 1.
// - While closed, the request-to-send pin is a plain general-purpose input or output.
// - Opening the port asserts request-to-send.
// - With flow control latched at open, host request-to-send writes do nothing.
// - Request-to-send write: zero deasserts, any non-zero value asserts.
// - Break write: non-zero starts a break, zero releases it.
// - A break holds the transmit line low longer than a 13-bit frame.
// - Without break hardware, break writes are accepted and ignored.
// - Flush, clear-to-send, request-to-send and break requests fail while closed.
`ifndef UFM_DEFINES_VH
`define UFM_DEFINES_VH

// ----
// Register offsets (byte addresses)
// ----
`define UFM_OFS_CTRL 8'h00
`define UFM_OFS_FLUSH 8'h04
`define UFM_OFS_CTS 8'h08
`define UFM_OFS_RTS 8'h0c
`define UFM_OFS_BRK 8'h10
`define UFM_OFS_STAT 8'h14
`define UFM_OFS_GPIO 8'h18
`define UFM_OFS_TXD 8'h1c
`define UFM_OFS_RXD 8'h20

// ----
// Field positions
// ----
`define UFM_CTRL_OPEN 0
`define UFM_CTRL_FLOW 1
`define UFM_FL_RX 0
`define UFM_FL_TX 1
`define UFM_GPIO_OUT 0
`define UFM_GPIO_OE 1

// ----
// Reset values, sizes and bus answers
// ----
`define UFM_GPIO_RST 2'h1
`define UFM_RING_DEPTH 4'h8
`define UFM_RESP_OK 2'h0
`define UFM_RESP_SLV 2'h2
`define UFM_RESP_DEC 2'h3

// ----
// Timing
// ----
`define UFM_CLK_HZ 125000000
`define UFM_BAUD 115200
`define UFM_BIT_DIV (`UFM_CLK_HZ / `UFM_BAUD)
`define UFM_BRK_MIN_BITS 4'he
`define UFM_GUARD_BITS 4'h2

`endif

// ---- hw/ufm_buf2.v ----
`default_nettype none

// ----
// Two-entry buffer between the transmit ring and the serializer
// ----
module ufm_buf2 #(
    parameter WIDTH = 8
) (
    // Clock and reset.
    input wire clk_i,
    input wire srst_i,
    // Control.
    input wire flush_i,
    input wire stall_i,
    // Filling side.
    input wire s_valid_i,
    input wire [WIDTH-1:0] s_data_i,
    output reg s_ready_o,
    // Draining side.
    output reg m_valid_o,
    output reg [WIDTH-1:0] m_data_o,
    input wire m_ready_i
);

    reg v0_r;
    reg v1_r;
    reg [WIDTH-1:0] d1_r;
    reg v0_nxt;
    reg v1_nxt;
    reg [WIDTH-1:0] d0_nxt;
    reg [WIDTH-1:0] d1_nxt;
    wire pop = m_valid_o & m_ready_i;
    wire push = s_valid_i & s_ready_o;

    // Entry 0 is always the head, so the output data is a plain flop.
    always @* begin
        v0_nxt = v0_r;
        v1_nxt = v1_r;
        d0_nxt = m_data_o;
        d1_nxt = d1_r;
        if (pop) begin
            v0_nxt = v1_r;
            d0_nxt = d1_r;
            v1_nxt = 1'b0;
        end
        if (push) begin
            if (!v0_nxt) begin
                v0_nxt = 1'b1;
                d0_nxt = s_data_i;
            end else begin
                v1_nxt = 1'b1;
                d1_nxt = s_data_i;
            end
        end
        if (flush_i) begin
            v0_nxt = 1'b0;
            v1_nxt = 1'b0;
        end
    end

    // A stall only withholds a new offer; one already shown stays until taken.
    always @(posedge clk_i) begin
        if (srst_i) begin
            v0_r <= 1'b0;
            v1_r <= 1'b0;
            d1_r <= {WIDTH{1'b0}};
            m_data_o <= {WIDTH{1'b0}};
            m_valid_o <= 1'b0;
            s_ready_o <= 1'b0;
        end else begin
            v0_r <= v0_nxt;
            v1_r <= v1_nxt;
            d1_r <= d1_nxt;
            m_data_o <= d0_nxt;
            m_valid_o <= v0_nxt & (~stall_i | (m_valid_o & ~pop & ~flush_i));
            s_ready_o <= ~v1_nxt;
        end
    end

endmodule

`default_nettype wire

// ---- hw/ufm_top.v ----
// Added by the designer: the register addresses and the AXI4-Lite interface to the registers.
`include "ufm_defines.vh"
`default_nettype none

// ----
// UART buffer clear, modem line and break control
// ----
module ufm_top #(
    parameter HAS_CTS = 1,
    parameter HAS_BRK = 1
) (
    // Clock and reset.
    input wire CLK_SYS_I,
    input wire SRST_I,
    // AXI4-Lite write channels.
    input wire [7:0] S_AXI_AWADDR_I,
    input wire S_AXI_AWVALID_I,
    output reg S_AXI_AWREADY_O,
    input wire [31:0] S_AXI_WDATA_I,
    input wire [3:0] S_AXI_WSTRB_I,
    input wire S_AXI_WVALID_I,
    output reg S_AXI_WREADY_O,
    output reg [1:0] S_AXI_BRESP_O,
    output reg S_AXI_BVALID_O,
    input wire S_AXI_BREADY_I,
    // AXI4-Lite read channels.
    input wire [7:0] S_AXI_ARADDR_I,
    input wire S_AXI_ARVALID_I,
    output reg S_AXI_ARREADY_O,
    output reg [31:0] S_AXI_RDATA_O,
    output reg [1:0] S_AXI_RRESP_O,
    output reg S_AXI_RVALID_O,
    input wire S_AXI_RREADY_I,
    // Received bytes from the deserializer.
    input wire [7:0] RX_DATA_I,
    input wire RX_VALID_I,
    output reg RX_READY_O,
    // Bytes to the serializer.
    output wire [7:0] TX_DATA_O,
    output wire TX_VALID_O,
    input wire TX_READY_I,
    // Serial line and modem pins.
    input wire TXD_SER_I,
    output reg TXD_O,
    input wire CTS_N_I,
    input wire RTS_N_I,
    output reg RTS_N_O,
    output reg RTS_OE_O
);

    // ------------------------------------------------------------------
    // Break sequencer states
    // ------------------------------------------------------------------
    localparam ST_LINE = 3'b001;
    localparam ST_BRK = 3'b010;
    localparam ST_GUARD = 3'b100;
    localparam integer BIT_DIV_W = `UFM_BIT_DIV - 1;
    localparam [10:0] BIT_DIV_M1 = BIT_DIV_W[10:0];

    // ------------------------------------------------------------------
    // Declarations
    // ------------------------------------------------------------------
    reg aw_have_r;
    reg [7:0] aw_addr_r;
    reg w_have_r;
    reg [31:0] w_data_r;
    reg [3:0] w_strb_r;
    reg open_r;
    reg flow_req_r;
    reg flow_r;
    reg rts_lvl_r;
    reg brk_req_r;
    reg [1:0] gpio_r;
    reg cts_s1_r;
    reg cts_s2_r;
    reg rts_s1_r;
    reg rts_s2_r;
    reg [7:0] rx_mem_r [0:7];
    reg [2:0] rx_wp_r;
    reg [2:0] rx_rp_r;
    reg [3:0] rx_cnt_r;
    reg [7:0] tx_mem_r [0:7];
    reg [2:0] tx_wp_r;
    reg [2:0] tx_rp_r;
    reg [3:0] tx_cnt_r;
    reg [2:0] brk_st_r;
    reg [3:0] brk_cnt_r;
    reg [10:0] div_cnt_r;
    reg bit_tick_r;
    reg [31:0] rd_val;
    reg [1:0] rd_resp;
    reg [1:0] wr_resp;
    reg rd_known;
    reg [3:0] rx_cnt_nxt;
    wire buf_ready;
    genvar gi;

    // Byte lanes that the strobes leave out write as zero.
    wire [31:0] wd = w_data_r & {{8{w_strb_r[3]}}, {8{w_strb_r[2]}},
                                  {8{w_strb_r[1]}}, {8{w_strb_r[0]}}};
    wire do_wr = aw_have_r & w_have_r & ~S_AXI_BVALID_O;
    wire do_rd = S_AXI_ARVALID_I & S_AXI_ARREADY_O;
    wire wr_flush = do_wr & (aw_addr_r == `UFM_OFS_FLUSH) & open_r;
    wire flush_rx = wr_flush & wd[`UFM_FL_RX];
    wire flush_tx = wr_flush & wd[`UFM_FL_TX];
    wire wr_ctrl = do_wr & (aw_addr_r == `UFM_OFS_CTRL);
    wire open_nxt = wr_ctrl ? wd[`UFM_CTRL_OPEN] : open_r;
    wire rx_full = (rx_cnt_r == `UFM_RING_DEPTH);
    wire tx_full = (tx_cnt_r == `UFM_RING_DEPTH);
    wire rx_empty = (rx_cnt_r == 4'h0);
    wire rx_push = RX_VALID_I & RX_READY_O;
    wire rx_pop = do_rd & (S_AXI_ARADDR_I == `UFM_OFS_RXD) & open_r & ~rx_empty;
    wire tx_push = do_wr & (aw_addr_r == `UFM_OFS_TXD) & open_r & ~tx_full;
    wire tx_pop = (tx_cnt_r != 4'h0) & buf_ready & ~flush_tx;
    wire cts_now = (HAS_CTS != 0) ? ~cts_s2_r : 1'b1;

    // ------------------------------------------------------------------
    // Pin synchronisers
    // ------------------------------------------------------------------
    // Modem pins are asynchronous to the system clock.
    always @(posedge CLK_SYS_I) begin
        if (SRST_I) begin
            cts_s1_r <= 1'b1;
            cts_s2_r <= 1'b1;
            rts_s1_r <= 1'b1;
            rts_s2_r <= 1'b1;
        end else begin
            cts_s1_r <= CTS_N_I;
            cts_s2_r <= cts_s1_r;
            rts_s1_r <= RTS_N_I;
            rts_s2_r <= rts_s1_r;
        end
    end

    // ------------------------------------------------------------------
    // AXI4-Lite write path
    // ------------------------------------------------------------------
    // Address and data are taken in either order; one write at a time.
    always @(posedge CLK_SYS_I) begin
        if (SRST_I) begin
            aw_have_r <= 1'b0;
            aw_addr_r <= 8'h00;
            w_have_r <= 1'b0;
            w_data_r <= 32'h00000000;
            w_strb_r <= 4'h0;
            S_AXI_AWREADY_O <= 1'b1;
            S_AXI_WREADY_O <= 1'b1;
            S_AXI_BVALID_O <= 1'b0;
            S_AXI_BRESP_O <= `UFM_RESP_OK;
        end else begin
            if (S_AXI_AWVALID_I && S_AXI_AWREADY_O) begin
                aw_have_r <= 1'b1;
                aw_addr_r <= S_AXI_AWADDR_I;
                S_AXI_AWREADY_O <= 1'b0;
            end
            if (S_AXI_WVALID_I && S_AXI_WREADY_O) begin
                w_have_r <= 1'b1;
                w_data_r <= S_AXI_WDATA_I;
                w_strb_r <= S_AXI_WSTRB_I;
                S_AXI_WREADY_O <= 1'b0;
            end
            if (do_wr) begin
                aw_have_r <= 1'b0;
                w_have_r <= 1'b0;
                S_AXI_BVALID_O <= 1'b1;
                S_AXI_BRESP_O <= wr_resp;
            end
            if (S_AXI_BVALID_O && S_AXI_BREADY_I) begin
                S_AXI_BVALID_O <= 1'b0;
                S_AXI_AWREADY_O <= 1'b1;
                S_AXI_WREADY_O <= 1'b1;
            end
        end
    end

    // Requests that need an open port answer with a slave error when closed.
    always @* begin
        case (aw_addr_r)
            `UFM_OFS_CTRL, `UFM_OFS_GPIO, `UFM_OFS_CTS, `UFM_OFS_STAT,
            `UFM_OFS_RXD: wr_resp = `UFM_RESP_OK;
            `UFM_OFS_FLUSH, `UFM_OFS_RTS, `UFM_OFS_BRK: begin
                wr_resp = open_r ? `UFM_RESP_OK : `UFM_RESP_SLV;
            end
            `UFM_OFS_TXD: wr_resp = (open_r & ~tx_full) ? `UFM_RESP_OK : `UFM_RESP_SLV;
            default: wr_resp = `UFM_RESP_DEC;
        endcase
    end

    // ------------------------------------------------------------------
    // Control registers
    // ------------------------------------------------------------------
    // Flow ownership is fixed when the port opens and kept until it closes.
    always @(posedge CLK_SYS_I) begin
        if (SRST_I) begin
            open_r <= 1'b0;
            flow_req_r <= 1'b0;
            flow_r <= 1'b0;
            rts_lvl_r <= 1'b0;
            brk_req_r <= 1'b0;
            gpio_r <= `UFM_GPIO_RST;
        end else begin
            if (wr_ctrl) begin
                open_r <= wd[`UFM_CTRL_OPEN];
                flow_req_r <= wd[`UFM_CTRL_FLOW];
                if (wd[`UFM_CTRL_OPEN] && !open_r) begin
                    rts_lvl_r <= 1'b1;
                    flow_r <= wd[`UFM_CTRL_FLOW];
                end
            end
            if (do_wr && aw_addr_r == `UFM_OFS_GPIO) begin
                gpio_r <= wd[1:0];
            end
            // Writes while flow control owns the line are dropped.
            if (do_wr && aw_addr_r == `UFM_OFS_RTS && open_r && !flow_r) begin
                rts_lvl_r <= (wd != 32'h00000000);
            end
            // Without break hardware the write is taken but changes nothing.
            if (do_wr && aw_addr_r == `UFM_OFS_BRK && open_r && HAS_BRK != 0) begin
                brk_req_r <= (wd != 32'h00000000);
            end
            // Closing the port drops a pending break with it.
            if (!open_nxt) begin
                brk_req_r <= 1'b0;
            end
        end
    end

    // ------------------------------------------------------------------
    // Request-to-send pin
    // ------------------------------------------------------------------
    // Open: driven by flow control or the host level; closed: general purpose.
    always @(posedge CLK_SYS_I) begin
        if (SRST_I) begin
            RTS_N_O <= 1'b1;
            RTS_OE_O <= 1'b0;
        end else if (open_r) begin
            RTS_OE_O <= 1'b1;
            if (flow_r) begin
                RTS_N_O <= rx_cnt_nxt == `UFM_RING_DEPTH;
            end else begin
                RTS_N_O <= ~rts_lvl_r;
            end
        end else begin
            RTS_N_O <= gpio_r[`UFM_GPIO_OUT];
            RTS_OE_O <= gpio_r[`UFM_GPIO_OE];
        end
    end

    // ------------------------------------------------------------------
    // Receive ring
    // ------------------------------------------------------------------
    always @* begin
        if (flush_rx) begin
            rx_cnt_nxt = {3'h0, rx_push};
        end else begin
            case ({rx_push, rx_pop})
                2'b10: rx_cnt_nxt = rx_cnt_r + 4'h1;
                2'b01: rx_cnt_nxt = rx_cnt_r - 4'h1;
                default: rx_cnt_nxt = rx_cnt_r;
            endcase
        end
    end

    // A byte arriving in the flush cycle survives the flush.
    always @(posedge CLK_SYS_I) begin
        if (SRST_I) begin
            rx_wp_r <= 3'h0;
            rx_rp_r <= 3'h0;
            rx_cnt_r <= 4'h0;
            RX_READY_O <= 1'b0;
        end else begin
            rx_cnt_r <= rx_cnt_nxt;
            RX_READY_O <= open_nxt & (rx_cnt_nxt != `UFM_RING_DEPTH);
            if (rx_push) begin
                rx_wp_r <= rx_wp_r + 3'h1;
            end
            if (flush_rx) begin
                rx_rp_r <= rx_wp_r;
            end else if (rx_pop) begin
                rx_rp_r <= rx_rp_r + 3'h1;
            end
        end
    end

    // ------------------------------------------------------------------
    // Transmit ring
    // ------------------------------------------------------------------
    // The flush drops queued bytes instead of draining them onto the line.
    always @(posedge CLK_SYS_I) begin
        if (SRST_I) begin
            tx_wp_r <= 3'h0;
            tx_rp_r <= 3'h0;
            tx_cnt_r <= 4'h0;
        end else begin
            if (tx_push) begin
                tx_wp_r <= tx_wp_r + 3'h1;
            end
            if (flush_tx) begin
                tx_rp_r <= tx_wp_r;
                tx_cnt_r <= {3'h0, tx_push};
            end else begin
                if (tx_pop) begin
                    tx_rp_r <= tx_rp_r + 3'h1;
                end
                case ({tx_push, tx_pop})
                    2'b10: tx_cnt_r <= tx_cnt_r + 4'h1;
                    2'b01: tx_cnt_r <= tx_cnt_r - 4'h1;
                    default: tx_cnt_r <= tx_cnt_r;
                endcase
            end
        end
    end

    // Ring storage, one write port per entry.
    generate
        for (gi = 0; gi < 8; gi = gi + 1) begin : g_ring
            always @(posedge CLK_SYS_I) begin
                if (rx_push && rx_wp_r == gi) begin
                    rx_mem_r[gi] <= RX_DATA_I;
                end
                if (tx_push && tx_wp_r == gi) begin
                    tx_mem_r[gi] <= wd[7:0];
                end
            end
        end
    endgenerate

    // Held bytes also count as queued and go with a transmit flush.
    ufm_buf2 #(
        .WIDTH(8)
    ) u_buf (
        .clk_i(CLK_SYS_I),
        .srst_i(SRST_I),
        .flush_i(flush_tx),
        .stall_i(brk_st_r != ST_LINE),
        .s_valid_i(tx_pop),
        .s_data_i(tx_mem_r[tx_rp_r]),
        .s_ready_o(buf_ready),
        .m_valid_o(TX_VALID_O),
        .m_data_o(TX_DATA_O),
        .m_ready_i(TX_READY_I)
    );

    // ------------------------------------------------------------------
    // Bit-time enable and break sequencer
    // ------------------------------------------------------------------
    always @(posedge CLK_SYS_I) begin
        if (SRST_I) begin
            div_cnt_r <= 11'h000;
            bit_tick_r <= 1'b0;
        end else begin
            bit_tick_r <= (div_cnt_r == BIT_DIV_M1);
            div_cnt_r <= (div_cnt_r == BIT_DIV_M1) ? 11'h000 : div_cnt_r + 11'h001;
        end
    end

    // A released break still runs its minimum length, then idles high.
    always @(posedge CLK_SYS_I) begin
        if (SRST_I) begin
            brk_st_r <= ST_LINE;
            brk_cnt_r <= 4'h0;
            TXD_O <= 1'b1;
        end else begin
            case (brk_st_r)
                ST_LINE: begin
                    TXD_O <= TXD_SER_I;
                    brk_cnt_r <= 4'h0;
                    if (brk_req_r) begin
                        brk_st_r <= ST_BRK;
                        TXD_O <= 1'b0;
                    end
                end
                ST_BRK: begin
                    TXD_O <= 1'b0;
                    if (bit_tick_r && brk_cnt_r != `UFM_BRK_MIN_BITS) begin
                        brk_cnt_r <= brk_cnt_r + 4'h1;
                    end
                    if (!brk_req_r && brk_cnt_r == `UFM_BRK_MIN_BITS) begin
                        brk_st_r <= ST_GUARD;
                        brk_cnt_r <= 4'h0;
                        TXD_O <= 1'b1;
                    end
                end
                ST_GUARD: begin
                    TXD_O <= 1'b1;
                    if (brk_req_r) begin
                        brk_st_r <= ST_BRK;
                        brk_cnt_r <= 4'h0;
                        TXD_O <= 1'b0;
                    end else if (bit_tick_r) begin
                        brk_cnt_r <= brk_cnt_r + 4'h1;
                        if (brk_cnt_r + 4'h1 == `UFM_GUARD_BITS) begin
                            brk_st_r <= ST_LINE;
                        end
                    end
                end
                default: begin
                    brk_st_r <= ST_LINE;
                    TXD_O <= 1'b1;
                end
            endcase
        end
    end

    // ------------------------------------------------------------------
    // AXI4-Lite read path
    // ------------------------------------------------------------------
    always @* begin
        rd_val = 32'h00000000;
        rd_known = 1'b1;
        case (S_AXI_ARADDR_I)
            `UFM_OFS_CTRL: rd_val = {29'h0, flow_r, flow_req_r, open_r};
            `UFM_OFS_FLUSH: rd_val = 32'h00000000;
            `UFM_OFS_CTS: rd_val = {31'h0, cts_now};
            `UFM_OFS_RTS: rd_val = {31'h0, rts_lvl_r};
            `UFM_OFS_BRK: rd_val = {31'h0, brk_req_r};
            `UFM_OFS_STAT: begin
                rd_val = {14'h0, brk_st_r != ST_LINE, flow_r, 4'h0, tx_cnt_r,
                          4'h0, rx_cnt_r};
            end
            `UFM_OFS_GPIO: rd_val = {29'h0, ~rts_s2_r, gpio_r};
            `UFM_OFS_TXD: rd_val = 32'h00000000;
            `UFM_OFS_RXD: rd_val = rx_empty ? 32'h00000000 : {23'h0, 1'b1, rx_mem_r[rx_rp_r]};
            default: rd_known = 1'b0;
        endcase
    end

    // Reads that need an open port answer with a slave error when closed.
    always @* begin
        if (!rd_known) begin
            rd_resp = `UFM_RESP_DEC;
        end else if (!open_r && (S_AXI_ARADDR_I == `UFM_OFS_CTS ||
                                 S_AXI_ARADDR_I == `UFM_OFS_RXD)) begin
            rd_resp = `UFM_RESP_SLV;
        end else begin
            rd_resp = `UFM_RESP_OK;
        end
    end

    // Answer one cycle after the address is taken.
    always @(posedge CLK_SYS_I) begin
        if (SRST_I) begin
            S_AXI_ARREADY_O <= 1'b1;
            S_AXI_RVALID_O <= 1'b0;
            S_AXI_RDATA_O <= 32'h00000000;
            S_AXI_RRESP_O <= `UFM_RESP_OK;
        end else begin
            if (do_rd) begin
                S_AXI_ARREADY_O <= 1'b0;
                S_AXI_RVALID_O <= 1'b1;
                S_AXI_RDATA_O <= (rd_resp == `UFM_RESP_OK) ? rd_val : 32'h00000000;
                S_AXI_RRESP_O <= rd_resp;
            end
            if (S_AXI_RVALID_O && S_AXI_RREADY_I) begin
                S_AXI_RVALID_O <= 1'b0;
                S_AXI_ARREADY_O <= 1'b1;
            end
        end
    end

endmodule

`default_nettype wire

// ---- verif/ufm_chk.sv ----
`default_nettype none
// ----
// Bus and pin checks
// ----
module ufm_chk (
    input wire logic CLK_SYS_I, SRST_I, S_AXI_AWVALID_I, S_AXI_AWREADY_O, S_AXI_WVALID_I,
    input wire logic S_AXI_WREADY_O, S_AXI_BVALID_O, S_AXI_BREADY_I, S_AXI_ARVALID_I,
    input wire logic S_AXI_ARREADY_O, S_AXI_RVALID_O, S_AXI_RREADY_I, TX_VALID_O,
    input wire logic TX_READY_I, TXD_O, RTS_N_O, RTS_OE_O,
    input wire logic [1:0] S_AXI_BRESP_O,
    input wire logic [31:0] S_AXI_RDATA_O,
    input wire logic [7:0] TX_DATA_O
);
    timeunit 1ns;
    timeprecision 1ns;
    default clocking @(posedge CLK_SYS_I); endclocking
    default disable iff (SRST_I);
    // Answers stand until taken.
    chk_b_stands: assert property (S_AXI_BVALID_O && !S_AXI_BREADY_I |=>
        S_AXI_BVALID_O && $stable(S_AXI_BRESP_O)) else $error("write answer dropped");
    chk_r_stands: assert property (S_AXI_RVALID_O && !S_AXI_RREADY_I |=>
        S_AXI_RVALID_O && $stable(S_AXI_RDATA_O)) else $error("read answer dropped");
    chk_b_latency: assert property (S_AXI_AWVALID_I && S_AXI_AWREADY_O &&
        S_AXI_WVALID_I && S_AXI_WREADY_O |-> ##[1:2] S_AXI_BVALID_O) else $error("late write");
    chk_r_latency: assert property (S_AXI_ARVALID_I && S_AXI_ARREADY_O |=>
        S_AXI_RVALID_O) else $error("late read");
    chk_w_busy: assert property (S_AXI_BVALID_O |->
        !S_AXI_AWREADY_O && !S_AXI_WREADY_O) else $error("write taken while busy");
    chk_r_busy: assert property (S_AXI_RVALID_O |-> !S_AXI_ARREADY_O)
        else $error("read taken while busy");
    chk_tx_held: assert property (TX_VALID_O && !TX_READY_I |=>
        !TX_VALID_O || $stable(TX_DATA_O)) else $error("offered byte changed");
    chk_reset_idle: assert property (disable iff (1'b0) SRST_I |=>
        TXD_O && RTS_N_O && !RTS_OE_O && !S_AXI_BVALID_O) else $error("not idle after reset");
endmodule
bind ufm_top ufm_chk chk_u (.CLK_SYS_I, .SRST_I, .S_AXI_AWVALID_I, .S_AXI_AWREADY_O,
    .S_AXI_WVALID_I, .S_AXI_WREADY_O, .S_AXI_BVALID_O, .S_AXI_BREADY_I, .S_AXI_ARVALID_I,
    .S_AXI_ARREADY_O, .S_AXI_RVALID_O, .S_AXI_RREADY_I, .TX_VALID_O, .TX_READY_I, .TXD_O,
    .RTS_N_O, .RTS_OE_O, .S_AXI_BRESP_O, .S_AXI_RDATA_O, .TX_DATA_O);
`default_nettype wire

// ---- verif/ufm_peer.sv ----
`default_nettype none
// ----
// Serial peer
// ----
module ufm_peer (
    input wire logic clk_i, rx_ready_i, tx_valid_i,
    input wire logic [7:0] tx_data_i,
    output logic [7:0] rx_data_o,
    output logic rx_valid_o, tx_ready_o, txd_ser_o, cts_n_o
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [7:0] got = 8'h00, n_got = 8'h00;
    // The line idles high and nothing is offered until a send.
    initial {rx_data_o, rx_valid_o, tx_ready_o, txd_ser_o, cts_n_o} = 12'h007;
    // Every byte taken is counted; only the last one taken is kept.
    always @(posedge clk_i) begin
        if (tx_valid_i && tx_ready_o) begin
            got <= tx_data_i;
            n_got <= n_got + 8'h01;
        end
    end
    // A byte is held until taken; the data lines then show junk.
    task send(input [7:0] b);
        @(posedge clk_i);
        rx_data_o <= b;
        rx_valid_o <= 1'b1;
        do @(posedge clk_i); while (rx_ready_i !== 1'b1);
        rx_valid_o <= 1'b0;
        rx_data_o <= ~b;
    endtask
endmodule
`default_nettype wire

// ---- verif/testbench.sv ----
`default_nettype none
// ----
// Register tests
// ----
module testbench;
    timeunit 1ns;
    timeprecision 1ns;
    logic clk, rst = 1'b1, awv = 1'b0, wv = 1'b0, bre = 1'b0, arv = 1'b0, rre = 1'b0;
    logic [7:0] aw = 8'h00, ar = 8'h00;
    logic [31:0] wd = 32'h0;
    wire logic awr, wrd, bv, arr, rv, rxr, rxv, txv, txr, txd, ser, cts_n, rts_n, rts_oe;
    wire logic [1:0] bresp, rresp;
    wire logic [31:0] rdata;
    wire logic [7:0] rxd, txdat;
    int fail_count = 0, n_tests = 0;
    ufm_top dut_u (.CLK_SYS_I(clk), .SRST_I(rst), .S_AXI_AWADDR_I(aw), .S_AXI_AWVALID_I(awv),
        .S_AXI_AWREADY_O(awr), .S_AXI_WDATA_I(wd), .S_AXI_WSTRB_I(4'hf), .S_AXI_WVALID_I(wv),
        .S_AXI_WREADY_O(wrd), .S_AXI_BRESP_O(bresp), .S_AXI_BVALID_O(bv), .S_AXI_BREADY_I(bre),
        .S_AXI_ARADDR_I(ar), .S_AXI_ARVALID_I(arv), .S_AXI_ARREADY_O(arr),
        .S_AXI_RDATA_O(rdata), .S_AXI_RRESP_O(rresp), .S_AXI_RVALID_O(rv), .S_AXI_RREADY_I(rre),
        .RX_DATA_I(rxd), .RX_VALID_I(rxv), .RX_READY_O(rxr), .TX_DATA_O(txdat), .TX_VALID_O(txv),
        .TX_READY_I(txr), .TXD_SER_I(ser), .TXD_O(txd), .CTS_N_I(cts_n),
        .RTS_N_I(rts_oe ? rts_n : 1'b1), .RTS_N_O(rts_n), .RTS_OE_O(rts_oe));
    ufm_peer peer_u (.clk_i(clk), .rx_ready_i(rxr), .tx_valid_i(txv), .tx_data_i(txdat),
        .rx_data_o(rxd), .rx_valid_o(rxv), .tx_ready_o(txr), .txd_ser_o(ser), .cts_n_o(cts_n));
    initial begin
        clk = 1'b0;
        forever #4 clk = ~clk;
    end
    task cmp(input [33:0] g, e);
        n_tests++;
        if (g !== e) begin
            fail_count++;
            $display("unexpected at %0t: got %h, expected %h", $time, g, e);
        end
    endtask
    // Address and data are offered together and each is released when taken.
    task wr(input [7:0] a, input [31:0] d, input [1:0] r);
        @(posedge clk);
        {aw, wd, awv, wv, bre} <= {a, d, 3'h7};
        do begin
            @(posedge clk);
            if (awr) awv <= 1'b0;
            if (wrd) wv <= 1'b0;
        end while (bv !== 1'b1);
        bre <= 1'b0;
        cmp(bresp, r);
    endtask
    task rd(input [7:0] a, input [31:0] e, input [1:0] r);
        @(posedge clk);
        {ar, arv, rre} <= {a, 2'h3};
        do begin
            @(posedge clk);
            if (arr) arv <= 1'b0;
        end while (rv !== 1'b1);
        rre <= 1'b0;
        cmp({rresp, rdata}, {r, e});
    endtask
    // The pin flops lag the register write by at most one cycle.
    task pin(input [1:0] e);
        repeat (3) @(posedge clk);
        cmp({rts_oe, rts_n}, e);
    endtask
    task cts(input v, input [31:0] e);
        @(posedge clk);
        peer_u.cts_n_o <= v;
        repeat (4) @(posedge clk);
        rd(8'h08, e, 2'h0);
    endtask
    task final_report;
        $display("comparisons %0d, mismatches %0d", n_tests, fail_count);
        if (fail_count == 0 && n_tests > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask
    initial begin
        repeat (40000) @(posedge clk);
        fail_count++;
        final_report;
    end
    initial begin
        repeat (12) @(posedge clk);
        rst <= 1'b0;
        for (int i = 1; i < 5; i++) if (i != 2) wr(8'(4 * i), 32'h1, 2'h2);
        rd(8'h08, 32'h0, 2'h2);
        wr(8'h18, 32'h3, 2'h0);
        pin(2'h3);
        wr(8'h18, 32'h2, 2'h0);
        pin(2'h2);
        rd(8'h18, 32'h6, 2'h0);
        $display("test closed done");
        wr(8'h00, 32'h1, 2'h0);
        pin(2'h2);
        wr(8'h0c, 32'h0, 2'h0);
        pin(2'h3);
        wr(8'h0c, 32'h5, 2'h0);
        pin(2'h2);
        cts(1'b0, 32'h1);
        cts(1'b1, 32'h0);
        rd(8'h24, 32'h0, 2'h3);
        $display("test modem done");
        for (int i = 1; i < 4; i++) peer_u.send(i[7:0]);
        rd(8'h20, 32'h101, 2'h0);
        wr(8'h04, 32'h1, 2'h0);
        rd(8'h14, 32'h0, 2'h0);
        rd(8'h20, 32'h0, 2'h0);
        @(posedge clk);
        peer_u.tx_ready_o <= 1'b0;
        for (int i = 1; i < 4; i++) wr(8'h1c, 32'h40 + i, 2'h0);
        peer_u.send(8'h77);
        cmp({txv, txdat}, 32'h141);
        wr(8'h04, 32'h3, 2'h0);
        rd(8'h14, 32'h0, 2'h0);
        cmp(txv, 32'h0);
        @(posedge clk);
        peer_u.tx_ready_o <= 1'b1;
        wr(8'h1c, 32'h55, 2'h0);
        repeat (8) @(posedge clk);
        cmp({peer_u.n_got, peer_u.got}, 32'h155);
        $display("test flush done");
        wr(8'h10, 32'h9, 2'h0);
        wr(8'h10, 32'h0, 2'h0);
        cmp(txd, 32'h0);
        repeat (13 * 1085 - 8) @(posedge clk);
        cmp(txd, 32'h0);
        repeat (3 * 1085) @(posedge clk);
        cmp(txd, 32'h1);
        $display("test break done");
        wr(8'h00, 32'h0, 2'h0);
        wr(8'h00, 32'h3, 2'h0);
        for (int i = 0; i < 8; i++) peer_u.send(i[7:0]);
        rd(8'h14, 32'h10008, 2'h0);
        pin(2'h3);
        wr(8'h0c, 32'h5, 2'h0);
        pin(2'h3);
        wr(8'h04, 32'h1, 2'h0);
        pin(2'h2);
        $display("test flow done");
        final_report;
    end
endmodule
`default_nettype wire
